// file: design/link_diag_defs.vh
// Purpose: Constants of the link diagnostics, quality monitor and interrupt block.
// Assumes: 125 MHz system clock; register indices are word indices on APB.
// Notes:   Byte address of a register is four times its index.
// Overview of operation
// - Interrupts off after reset; enable and mask gate.
// - Unmasked pending event drives pin low immediately.
// - Status upper byte shows every pending source.
// - Status read clears all but events of the same cycle; pin releases.
// - Mask 0060h unmasks energy and link sources.
// - Diagnostic registers live on page two.
// - Polarity inversion shown in two status registers.
// - Polarity valid only 10 Mb or autonegotiated.
// - Crossover selection shown in status bit 14.
// - Cable length valid at 100 Mb link.
// - Frequency offset or control, low byte.
// - Variance period selectable 2, 4, 6, 8 ms.
// - 32-bit variance read as two halves.
// - Monitor control: enable and per-parameter warnings.
// - Variance has high warning on upper half only.
// - Extreme threshold disables its comparison.
// - Reset enable restarts adaption on violation.
// - Signal detect option zero also drops link.
// - Sample flag latches selected parameter value.
// - Output enable bit makes pin interrupt output.
// - Warning only when strictly beyond threshold.
`ifndef LINK_DIAG_DEFS_VH
`define LINK_DIAG_DEFS_VH

// Register indices.
`define IDX_PHY_STATUS      5'h10
`define IDX_IRQ_CONTROL     5'h11
`define IDX_IRQ_STATUS      5'h12
`define IDX_PAGE_SELECT     5'h13
`define IDX_CABLE_LENGTH    5'h14
`define IDX_FREQ_OFFSET     5'h15
`define IDX_TEN_MB_STATUS   5'h1a
`define IDX_VAR_CONTROL     5'h1a
`define IDX_VAR_DATA        5'h1b
`define IDX_QUALITY_CTRL_2  5'h1c
`define IDX_QUALITY_CTRL    5'h1d
`define IDX_QUALITY_DATA    5'h1e
`define DIAG_PAGE           16'h0002

// Interrupt control fields.
`define IRQ_OE_BIT          0
`define IRQ_MASTER_EN_BIT   1
// Interrupt status: mask in low byte, pending in high byte.
`define IRQ_ENERGY_SRC      5
`define IRQ_LINK_SRC        6
`define IRQ_QUALITY_SRC     7

// Status bit positions.
`define PHY_LINK_BIT        0
`define PHY_SPEED10_BIT     1
`define PHY_POLARITY_BIT    12
`define PHY_MDIX_BIT        14
`define TEN_POLARITY_BIT    4
`define FREQ_SEL_BIT        15

// Variance control fields.
`define VAR_EN_BIT          0
`define VAR_SEL_LSB         1

// Quality monitor fields.
`define LQ_ENABLE_BIT       15
`define LQ_RESET_EN_LSB     10
`define LQ2_VAR_WARN_BIT    0
`define LQ2_VAR_RESET_BIT   1
`define LQD_SAMPLE_BIT      13
`define LQD_WRITE_THR_BIT   12
`define LQD_SEL_LSB         9
`define LQD_HIGH_BIT        8
`define LQ_NUM_PARAMS       5

// Reset values.
`define RST_ZERO16          16'h0000
`define THR_SIGNED_MIN      8'h80
`define THR_SIGNED_MAX      8'h7f
`define THR_UNSIGNED_MIN    8'h00
`define THR_UNSIGNED_MAX    8'hff
`define THR_VAR_MAX         16'hffff

// Timing.
`define CLK_PERIOD_NS       8
`define VAR_STEP_NS         2000000
`define VAR_STEP_CYCLES     (`VAR_STEP_NS / `CLK_PERIOD_NS)

`endif

// file: design/threshold_compare.v
// Purpose: Strict high and low threshold comparison of one adapted parameter.
// Assumes: Value and thresholds share one encoding, signed or unsigned.
// Notes:   Equal values never warn.
`timescale 1ns/1ps
module threshold_compare #(
    parameter W      = 8,
    parameter SIGNED = 1
) (
    // Operands.
    input  wire [W-1:0] value,
    input  wire [W-1:0] thr_high,
    input  wire [W-1:0] thr_low,
    // Results.
    output wire         above_high,
    output wire         below_low
);
    // Flipping the sign bit maps signed order onto unsigned order.
    wire [W-1:0] flip = SIGNED ? {1'b1, {(W-1){1'b0}}} : {W{1'b0}};
    wire [W-1:0] v    = value ^ flip;
    wire [W-1:0] h    = thr_high ^ flip;
    wire [W-1:0] l    = thr_low ^ flip;

    assign above_high = (v > h);
    assign below_low  = (v < l);
endmodule // threshold_compare

// file: design/link_diag_quality_irq.v
// Purpose: Link diagnostics status, quality monitor and interrupt logic on APB.
// Assumes: Core inputs are synchronous to sys_clk; APB word index is paddr[6:2].
// Notes:   Registers at index 10h to 13h are visible on every page.
`timescale 1ns/1ps
`include "link_diag_defs.vh"
module link_diag_quality_irq #(
    parameter VAR_STEP_CYCLES = `VAR_STEP_CYCLES
) (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        reset,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Link state from the transceiver core.
    input  wire        link_up,
    input  wire        speed_100,
    input  wire        autoneg_mode,
    input  wire        polarity_inverted,
    input  wire        mdix_active,
    input  wire        signal_detect_option,
    input  wire [7:0]  cable_length,
    // Adapted parameters from the signal processor.
    input  wire [7:0]  equalizer_coefficient,
    input  wire [7:0]  adaptive_gain,
    input  wire [7:0]  baseline_wander,
    input  wire [7:0]  frequency_offset,
    input  wire [7:0]  frequency_control,
    input  wire [7:0]  squared_error,
    // Interrupt events from elsewhere in the device.
    input  wire [4:0]  other_events,
    input  wire        energy_change_evt,
    input  wire        link_change_evt,
    // Shared power-down and interrupt pin, open drain.
    input  wire        powerdown_irq_pin_in,
    output reg         powerdown_irq_pin_out,
    output reg         powerdown_irq_pin_oe,
    // Control to the core.
    output reg         power_down_req,
    output reg         adaption_restart,
    output reg         link_status_drop
);
    // Registers.
    reg  [15:0] irq_control_reg_r;
    reg  [7:0]  irq_mask_r;
    reg  [7:0]  irq_pending_r;
    reg  [7:0]  irq_pending_nxt;
    reg  [15:0] page_select_reg_r;
    reg         freq_sel_r;
    reg  [15:0] var_control_r;
    reg  [20:0] var_cnt_r;
    reg  [1:0]  var_step_r;
    reg  [31:0] var_acc_r;
    reg  [31:0] var_sum_r;
    reg  [15:0] var_hold_r;
    reg         var_phase_r;
    reg         lq_enable_r;
    reg  [4:0]  lq_reset_en_r;
    reg  [9:0]  lq_warn_r;
    reg  [9:0]  lq_warn_nxt;
    reg         lq_var_reset_en_r;
    reg         lq_var_warn_r;
    reg  [7:0]  sample_r;
    reg  [2:0]  sel_r;
    reg  [7:0]  thr_high_r [0:4];
    reg  [7:0]  thr_low_r  [0:4];
    reg  [15:0] thr_var_r;
    reg  [15:0] rd_mux;
    reg         rd_hit;

    wire [4:0]  idx      = paddr[6:2];
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable & pready;
    wire        wr_acc   = access & pwrite & ~pslverr;
    wire        rd_acc   = access & ~pwrite & ~pslverr;
    wire        page2    = (page_select_reg_r == `DIAG_PAGE);
    wire        speed10  = ~speed_100;
    wire        link100  = link_up & speed_100;
    wire        pol_ok   = polarity_inverted & (speed10 | autoneg_mode);
    wire [7:0]  adapted [0:4];
    wire [4:0]  above;
    wire [4:0]  below;
    wire        var_above;
    wire [4:0]  viol;
    wire        var_viol;
    wire        restart;
    wire        wr_qdata = wr_acc & page2 & (idx == `IDX_QUALITY_DATA);
    wire [2:0]  wsel     = pwdata[`LQD_SEL_LSB+2:`LQD_SEL_LSB];
    wire [20:0] var_top;

    assign adapted[0] = equalizer_coefficient;
    assign adapted[1] = adaptive_gain;
    assign adapted[2] = baseline_wander;
    assign adapted[3] = frequency_offset;
    assign adapted[4] = frequency_control;

    // Only the gain parameter is unsigned.
    genvar g;
    generate
        for (g = 0; g < `LQ_NUM_PARAMS; g = g + 1) begin : cmp
            threshold_compare #(.W(8), .SIGNED(g != 1)) u_cmp (
                .value      (adapted[g]),
                .thr_high   (thr_high_r[g]),
                .thr_low    (thr_low_r[g]),
                .above_high (above[g]),
                .below_low  ()
            );
            assign below[g] = (g == 1) ? (adapted[g] < thr_low_r[g])
                            : ((adapted[g] ^ 8'h80) < (thr_low_r[g] ^ 8'h80));
            assign viol[g]  = lq_enable_r & (above[g] | below[g]);
        end
    endgenerate

    threshold_compare #(.W(16), .SIGNED(0)) u_var_cmp (
        .value      (var_sum_r[31:16]),
        .thr_high   (thr_var_r),
        .thr_low    (16'h0000),
        .above_high (var_above),
        .below_low  ()
    );
    assign var_viol = lq_enable_r & var_above;
    assign restart  = |(viol & lq_reset_en_r) | (var_viol & lq_var_reset_en_r);

    // Read multiplexer; page-two registers hide on other pages.
    always @* begin
        rd_mux = 16'h0000;
        rd_hit = 1'b1;
        case (idx)
            `IDX_PHY_STATUS: begin
                rd_mux[`PHY_LINK_BIT]     = link_up;
                rd_mux[`PHY_SPEED10_BIT]  = speed10;
                rd_mux[`PHY_POLARITY_BIT] = pol_ok;
                rd_mux[`PHY_MDIX_BIT]     = mdix_active;
            end
            `IDX_IRQ_CONTROL: rd_mux = irq_control_reg_r;
            `IDX_IRQ_STATUS:  rd_mux = {irq_pending_r, irq_mask_r};
            `IDX_PAGE_SELECT: rd_mux = page_select_reg_r;
            `IDX_CABLE_LENGTH: begin
                rd_mux = {8'h00, link100 ? cable_length : 8'h00};
                rd_hit = page2;
            end
            `IDX_FREQ_OFFSET: begin
                rd_mux[`FREQ_SEL_BIT] = freq_sel_r;
                rd_mux[7:0] = ~link100 ? 8'h00
                            : (freq_sel_r ? frequency_control : frequency_offset);
                rd_hit = page2;
            end
            `IDX_VAR_CONTROL: begin
                rd_mux = page2 ? var_control_r : {11'd0, pol_ok, 4'd0};
            end
            `IDX_VAR_DATA: begin
                rd_mux = var_phase_r ? var_hold_r : var_sum_r[15:0];
                rd_hit = page2;
            end
            `IDX_QUALITY_CTRL_2: begin
                rd_mux = {14'd0, lq_var_reset_en_r, lq_var_warn_r};
                rd_hit = page2;
            end
            `IDX_QUALITY_CTRL: begin
                rd_mux = {lq_enable_r, lq_reset_en_r, lq_warn_r};
                rd_hit = page2;
            end
            `IDX_QUALITY_DATA: begin
                rd_mux = {4'h0, sel_r, 9'h000} | {8'h00, sample_r};
                rd_hit = page2;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer: data latched in setup, access phase lasts one cycle.
    always @(posedge sys_clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~rd_hit;
            if (setup) begin
                prdata <= (rd_hit & ~pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
            end
        end
    end

    // Interrupt pending bits.
    always @* begin
        irq_pending_nxt = irq_pending_r;
        if (rd_acc & (idx == `IDX_IRQ_STATUS)) begin
            irq_pending_nxt = 8'h00;
        end
        irq_pending_nxt = irq_pending_nxt
                        | {3'b000, other_events}
                        | ({7'd0, energy_change_evt} << `IRQ_ENERGY_SRC)
                        | ({7'd0, link_change_evt} << `IRQ_LINK_SRC)
                        | ({7'd0, |(viol & ~lq_warn_r[4:0]) | (var_viol & ~lq_var_warn_r)}
                           << `IRQ_QUALITY_SRC);
    end

    // Control and interrupt registers.
    always @(posedge sys_clk) begin
        if (reset) begin
            irq_control_reg_r <= `RST_ZERO16;
            irq_mask_r        <= 8'h00;
            irq_pending_r     <= 8'h00;
            page_select_reg_r <= `RST_ZERO16;
            freq_sel_r        <= 1'b0;
            var_control_r     <= `RST_ZERO16;
        end else begin
            irq_pending_r <= irq_pending_nxt;
            if (wr_acc) begin
                case (idx)
                    `IDX_IRQ_CONTROL: irq_control_reg_r <= {14'd0, pwdata[1:0]};
                    `IDX_IRQ_STATUS:  irq_mask_r <= pwdata[7:0];
                    `IDX_PAGE_SELECT: page_select_reg_r <= pwdata[15:0];
                    `IDX_FREQ_OFFSET: begin
                        if (page2) begin
                            freq_sel_r <= pwdata[`FREQ_SEL_BIT];
                        end
                    end
                    `IDX_VAR_CONTROL: begin
                        if (page2) begin
                            var_control_r <= {13'd0, pwdata[2:0]};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Shared pin: open drain, driven low for an unmasked pending event.
    always @(posedge sys_clk) begin
        if (reset) begin
            powerdown_irq_pin_out <= 1'b0;
            powerdown_irq_pin_oe  <= 1'b0;
            power_down_req        <= 1'b0;
        end else begin
            powerdown_irq_pin_out <= 1'b0;
            powerdown_irq_pin_oe  <= irq_control_reg_r[`IRQ_OE_BIT]
                                   & irq_control_reg_r[`IRQ_MASTER_EN_BIT]
                                   & (|(irq_pending_nxt & irq_mask_r));
            power_down_req        <= ~irq_control_reg_r[`IRQ_OE_BIT] & ~powerdown_irq_pin_in;
        end
    end

    // period of 1 to 4 steps
    assign var_top = (21'd1 + {19'd0, var_control_r[`VAR_SEL_LSB+1:`VAR_SEL_LSB]})
                   * VAR_STEP_CYCLES[20:0] - 21'd1;

    // Variance accumulation and two-part read.
    always @(posedge sys_clk) begin
        if (reset) begin
            var_cnt_r   <= 21'd0;
            var_step_r  <= 2'd0;
            var_acc_r   <= 32'h0000_0000;
            var_sum_r   <= 32'h0000_0000;
            var_hold_r  <= 16'h0000;
            var_phase_r <= 1'b0;
        end else begin
            var_step_r <= 2'd0;
            if (var_control_r[`VAR_EN_BIT]) begin
                if (var_cnt_r >= var_top) begin
                    var_cnt_r <= 21'd0;
                    var_acc_r <= 32'h0000_0000;
                    var_sum_r <= var_acc_r + {24'd0, squared_error};
                end else begin
                    var_cnt_r <= var_cnt_r + 21'd1;
                    var_acc_r <= var_acc_r + {24'd0, squared_error};
                end
            end else begin
                var_cnt_r <= 21'd0;
                var_acc_r <= 32'h0000_0000;
            end
            // low half then held high half
            if (rd_acc & page2 & (idx == `IDX_VAR_DATA)) begin
                var_phase_r <= ~var_phase_r;
                if (!var_phase_r) begin
                    var_hold_r <= var_sum_r[31:16];
                end
            end
        end
    end

    // Quality warnings are sticky until their register is read.
    always @* begin
        lq_warn_nxt = lq_warn_r;
        if (rd_acc & page2 & (idx == `IDX_QUALITY_CTRL)) begin
            lq_warn_nxt = 10'd0;
        end
        lq_warn_nxt = lq_warn_nxt | {viol & below, viol & above};
    end

    // Quality monitor control, thresholds and sampling.
    integer i;
    always @(posedge sys_clk) begin
        if (reset) begin
            lq_enable_r       <= 1'b0;
            lq_reset_en_r     <= 5'd0;
            lq_warn_r         <= 10'd0;
            lq_var_reset_en_r <= 1'b0;
            lq_var_warn_r     <= 1'b0;
            sample_r          <= 8'h00;
            sel_r             <= 3'd0;
            thr_var_r         <= `THR_VAR_MAX;
            adaption_restart  <= 1'b0;
            link_status_drop  <= 1'b0;
            for (i = 0; i < `LQ_NUM_PARAMS; i = i + 1) begin
                thr_high_r[i] <= (i == 1) ? `THR_UNSIGNED_MAX : `THR_SIGNED_MAX;
                thr_low_r[i]  <= (i == 1) ? `THR_UNSIGNED_MIN : `THR_SIGNED_MIN;
            end
        end else begin
            lq_warn_r     <= lq_warn_nxt;
            lq_var_warn_r <= var_viol | (lq_var_warn_r
                           & ~(rd_acc & page2 & (idx == `IDX_QUALITY_CTRL_2)));
            adaption_restart <= restart;
            link_status_drop <= restart & ~signal_detect_option;
            if (wr_acc & page2 & (idx == `IDX_QUALITY_CTRL)) begin
                lq_enable_r   <= pwdata[`LQ_ENABLE_BIT];
                lq_reset_en_r <= pwdata[`LQ_RESET_EN_LSB+4:`LQ_RESET_EN_LSB];
            end
            if (wr_acc & page2 & (idx == `IDX_QUALITY_CTRL_2)) begin
                lq_var_reset_en_r <= pwdata[`LQ2_VAR_RESET_BIT];
            end
            if (wr_qdata) begin
                sel_r <= wsel;
                if (pwdata[`LQD_SAMPLE_BIT]) begin
                    case (wsel)
                        3'd0:    sample_r <= equalizer_coefficient;
                        3'd1:    sample_r <= adaptive_gain;
                        3'd2:    sample_r <= baseline_wander;
                        3'd3:    sample_r <= frequency_offset;
                        3'd4:    sample_r <= frequency_control;
                        3'd5:    sample_r <= var_sum_r[23:16];
                        default: sample_r <= 8'h00;
                    endcase
                end else if (pwdata[`LQD_WRITE_THR_BIT]) begin
                    if (wsel < 3'd5) begin
                        if (pwdata[`LQD_HIGH_BIT]) begin
                            thr_high_r[wsel] <= pwdata[7:0];
                        end else begin
                            thr_low_r[wsel] <= pwdata[7:0];
                        end
                    end else if ((wsel == 3'd5) & pwdata[`LQD_HIGH_BIT]) begin
                        thr_var_r <= {pwdata[7:0], 8'h00};
                    end
                end
            end
        end
    end
endmodule // link_diag_quality_irq

// file: tb/link_diag_props.sv
// Purpose: Port checker of the diagnostics, quality monitor and interrupt block.
// Assumes: One clock domain; reset synchronous and active high.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module link_diag_props (
    // Clock, reset and APB.
    input wire        sys_clk,
    input wire        reset,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Core side.
    input wire        link_up,
    input wire        speed_100,
    input wire        autoneg_mode,
    input wire        mdix_active,
    input wire        signal_detect_option,
    input wire        energy_change_evt,
    input wire        link_change_evt,
    // Pin and control outputs.
    input wire        powerdown_irq_pin_in,
    input wire        powerdown_irq_pin_out,
    input wire        powerdown_irq_pin_oe,
    input wire        power_down_req,
    input wire        adaption_restart,
    input wire        link_status_drop
);
    wire [4:0]  idx = paddr[6:2];
    wire        rd  = psel && penable && pready && !pwrite;
    reg  [15:0] page_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Shadow of the page select, so that refusals can be predicted.
    always @(posedge sys_clk) page_r <= reset ? 16'h0000 : (psel && penable && pready && pwrite
        && idx == 5'h13) ? pwdata[15:0] : page_r;

    rst_quiet_a: assert property ($fell(reset) |-> !powerdown_irq_pin_oe)
        else $error("pin driven after reset");
    pin_drain_a: assert property (!powerdown_irq_pin_out)
        else $error("pin driven high");
    clear_rel_a: assert property (rd && idx == 5'h12 && !link_change_evt && !energy_change_evt
        |=> !powerdown_irq_pin_oe) else $error("pin held after clear");
    page_err_a: assert property (psel && !penable && idx == 5'h14 && page_r != 16'h0002
        |=> pready && pslverr) else $error("page two access not refused");
    pol_forced_a: assert property (rd && idx == 5'h10 && $past(speed_100) && !$past(autoneg_mode)
        |-> !prdata[12]) else $error("polarity shown in forced mode");
    cross_flag_a: assert property (rd && idx == 5'h10 |-> prdata[14] == $past(mdix_active))
        else $error("crossover flag wrong");
    len_zero_a: assert property (rd && !pslverr && idx == 5'h14 && !$past(link_up)
        |-> prdata[15:0] == 16'h0000) else $error("length without link");
    drop_link_a: assert property (link_status_drop == (adaption_restart
        && !$past(signal_detect_option))) else $error("link drop mismatch");
    pd_req_a: assert property (power_down_req |-> !$past(powerdown_irq_pin_in)
        && !powerdown_irq_pin_oe) else $error("power down without low pin");
endmodule // link_diag_props

bind link_diag_quality_irq link_diag_props u_props (.*);

// file: tb/pin_host.sv
// Purpose: Host side of the shared power-down and interrupt pin.
// Assumes: The pin has a pull-up; the host may hold it low to ask for power down.
// Notes:   Open drain, so any party pulling low wins.
`timescale 1ns/1ps
module pin_host (
    // Drivers of the pin.
    input  wire powerdown_irq_pin_oe,
    input  wire hold_low,
    // Resolved pin level.
    output wire powerdown_irq_pin_in
);
    assign powerdown_irq_pin_in = (powerdown_irq_pin_oe || hold_low) ? 1'h0 : 1'h1;
endmodule // pin_host

// file: tb/testbench.sv
// Purpose: Self-checking bench of the diagnostics, quality monitor and interrupt block.
// Assumes: The slave answers after one access cycle; inputs change after rising edges.
// Notes:   Variance step shortened to three hundred cycles.
`timescale 1ns/1ps
module testbench;
    reg         sys_clk = 1'h0;
    reg         reset = 1'h1;
    reg         psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hold_low = 1'h0, e;
    reg  [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, q;
    reg         link_up = 1'h0, speed_100 = 1'h0, autoneg_mode = 1'h0, seen_restart = 1'h0;
    reg         polarity_inverted = 1'h0, mdix_active = 1'h0, signal_detect_option = 1'h0;
    reg  [7:0]  cable_length = 8'h00, baseline_wander = 8'h10, equalizer_coefficient = 8'h05;
    reg  [7:0]  adaptive_gain = 8'h40, frequency_offset = 8'h11, frequency_control = 8'h22;
    reg  [7:0]  squared_error = 8'h03;
    reg  [4:0]  other_events = 5'h00;
    reg         energy_change_evt = 1'h0, link_change_evt = 1'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, powerdown_irq_pin_in, powerdown_irq_pin_out;
    wire        powerdown_irq_pin_oe, power_down_req, adaption_restart, link_status_drop;
    integer     n_errors = 0, check_count = 0;

    link_diag_quality_irq #(.VAR_STEP_CYCLES(300)) DUT (.*);
    pin_host host (.*);
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) seen_restart <= seen_restart | adaption_restart;

    task stop_test;
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] expv, input [8*12-1:0] what);
        check_count = check_count + 1;
        if (seen !== expv) begin
            n_errors = n_errors + 1;
            $display("ERROR %0s expected %h seen %h", what, expv, seen);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task xfer(input w, input [4:0] idx, input [15:0] d);
        integer n;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {25'h0, idx, 2'h0};
        pwdata <= {16'h0000, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        n = 0;
        @(posedge sys_clk);
        while (pready !== 1'h1 && n < 16) begin
            n = n + 1;
            @(posedge sys_clk);
        end
        if (pready !== 1'h1) begin
            n_errors = n_errors + 1;
            stop_test;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task pulse;
        repeat (3) @(posedge sys_clk);
    endtask

    task t_init;
        xfer(0, 5'h11, 16'h0000);
        chk(q, 16'h0000, "irq_ctl");
        hold_low <= 1'h1;
        pulse;
        chk(power_down_req, 1'h1, "pd_req_on");
        xfer(1, 5'h11, 16'h0003);
        pulse;
        chk(power_down_req, 1'h0, "pd_req_off");
        hold_low <= 1'h0;
        $display("Test init done");
    endtask
    task t_irq;
        xfer(1, 5'h12, 16'h0060);
        other_events <= 5'h01;
        @(posedge sys_clk);
        other_events <= 5'h00;
        pulse;
        chk(powerdown_irq_pin_oe, 1'h0, "masked");
        link_change_evt <= 1'h1;
        energy_change_evt <= 1'h1;
        @(posedge sys_clk);
        link_change_evt <= 1'h0;
        energy_change_evt <= 1'h0;
        pulse;
        chk(powerdown_irq_pin_in, 1'h0, "pin_low");
        xfer(0, 5'h12, 16'h0000);
        chk(q, 16'h6160, "pending");
        pulse;
        chk(powerdown_irq_pin_in, 1'h1, "pin_high");
        // An event that stands at the clearing edge must stay pending.
        link_change_evt <= 1'h1;
        xfer(0, 5'h12, 16'h0000);
        link_change_evt <= 1'h0;
        xfer(0, 5'h12, 16'h0000);
        chk(q, 16'h4060, "clear_race");
        xfer(0, 5'h12, 16'h0000);
        chk(q, 16'h0060, "cleared");
        $display("Test irq done");
    endtask
    task t_diag;
        link_up <= 1'h1;
        polarity_inverted <= 1'h1;
        mdix_active <= 1'h1;
        xfer(0, 5'h10, 16'h0000);
        chk(q[15:12], 4'h5, "phy_flags");
        xfer(0, 5'h1a, 16'h0000);
        chk(q[4], 1'h1, "ten_mb_pol");
        speed_100 <= 1'h1;
        xfer(0, 5'h10, 16'h0000);
        chk(q[12], 1'h0, "forced_pol");
        xfer(0, 5'h14, 16'h0000);
        chk(e, 1'h1, "page_refuse");
        xfer(1, 5'h13, 16'h0002);
        cable_length <= 8'h2a;
        xfer(0, 5'h14, 16'h0000);
        chk(q, 16'h002a, "cable_len");
        xfer(1, 5'h15, 16'h8000);
        xfer(0, 5'h15, 16'h0000);
        chk(q, 16'h8022, "freq_ctl");
        $display("Test diag done");
    endtask
    task t_quality;
        xfer(1, 5'h1e, 16'h2400);
        xfer(0, 5'h1e, 16'h0000);
        chk(q, 16'h0410, "sample_bw");
        xfer(1, 5'h1e, 16'h1510);
        xfer(1, 5'h1d, 16'h9000);
        pulse;
        xfer(0, 5'h1d, 16'h0000);
        chk(q, 16'h9000, "equal_thr");
        baseline_wander <= 8'h11;
        pulse;
        xfer(0, 5'h1d, 16'h0000);
        chk(q, 16'h9004, "high_warn");
        chk(seen_restart, 1'h1, "restart");
        xfer(0, 5'h12, 16'h0000);
        chk(q[15], 1'h1, "quality_irq");
        $display("Test quality done");
    endtask
    task t_var;
        squared_error <= 8'hff;
        xfer(1, 5'h1a, 16'h0001);
        repeat (700) @(posedge sys_clk);
        xfer(0, 5'h1b, 16'h0000);
        chk(q, 16'h2ad4, "var_lo_2ms");
        xfer(0, 5'h1b, 16'h0000);
        chk(q, 16'h0001, "var_hi_2ms");
        xfer(1, 5'h1a, 16'h0003);
        repeat (1900) @(posedge sys_clk);
        xfer(0, 5'h1b, 16'h0000);
        chk(q, 16'h55a8, "var_lo_4ms");
        xfer(0, 5'h1b, 16'h0000);
        chk(q, 16'h0002, "var_hi_4ms");
        xfer(0, 5'h1c, 16'h0000);
        chk(q, 16'h0000, "var_no_warn");
        xfer(1, 5'h1e, 16'h1b00);
        xfer(0, 5'h1c, 16'h0000);
        chk(q, 16'h0001, "var_warn");
        $display("Test variance done");
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        t_init;
        t_irq;
        t_diag;
        t_quality;
        t_var;
        stop_test;
    end
endmodule // testbench
